/* File: rtl/tci_interp.sv */
// telegram command interpreter: parses command lines from the tcp byte
// stream, answers clear-statistics and fetch-result, pushes result telegrams
// assumes the tcp stack, the result source and the config are on this clock
`timescale 1ns/1ps

module tci_interp (
  input wire logic clock,
  input wire logic nrst,
  output logic [15:0] listen_port,
  input wire logic conn_up,
  input wire logic on_request,
  input wire logic acq_done,
  output logic stats_clear,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic res_valid,
  output logic res_ready,
  input wire logic [7:0] res_data,
  input wire logic res_last,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data
);

  typedef struct packed {
    tci_pkg::tci_tx_st_t st;
    logic [1:0] idx;
    logic [7:0] c0;
    logic [7:0] c1;
    logic [1:0] cnt;
    logic ack_pend;
    logic fetch_pend;
    logic acq_pend;
    logic clr;
  } tci_state_t;

  tci_state_t q;
  tci_state_t d;
  logic rx_fire;
  logic buf_in_valid;
  logic buf_in_ready;
  logic [7:0] buf_in_data;
  logic push;
  logic line_end;
  logic is_cs;
  logic is_fetch;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // cr or lf
  function automatic logic is_term(input logic [7:0] b);
    is_term = (b == tci_pkg::TCI_CHR_CR) || (b == tci_pkg::TCI_CHR_LF);
  endfunction

  // fixed letters of the acknowledge and the result header
  function automatic logic [7:0] fixed_byte(input tci_pkg::tci_tx_st_t s, input logic [1:0] i);
    fixed_byte = tci_pkg::TCI_CHR_LF;
    unique case (s)
      tci_pkg::TCI_TX_ACK: fixed_byte = (i == 2'h0) ? tci_pkg::TCI_CHR_A :
                                        (i == 2'h1) ? tci_pkg::TCI_CHR_C : tci_pkg::TCI_CHR_K;
      tci_pkg::TCI_TX_RDH: fixed_byte = (i == 2'h0) ? tci_pkg::TCI_CHR_R : tci_pkg::TCI_CHR_D;
      tci_pkg::TCI_TX_CR: fixed_byte = tci_pkg::TCI_CHR_CR;
      tci_pkg::TCI_TX_IDLE, tci_pkg::TCI_TX_PAY, tci_pkg::TCI_TX_LF: fixed_byte = tci_pkg::TCI_CHR_LF;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // ports and line decode
  // ----------------------------------------------------------------
  // fixed listen port
  assign listen_port = tci_pkg::TCI_LISTEN_PORT;
  assign stats_clear = q.clr;
  // one command in flight: hold the stream until its answer is queued
  assign rx_ready = ~(q.ack_pend | q.fetch_pend);
  assign rx_fire = rx_valid & rx_ready;
  // empty line means a second terminator
  assign line_end = rx_fire && is_term(rx_data) && (q.cnt != 2'h0);
  // code is exactly the first two characters
  assign is_cs = (q.cnt == tci_pkg::TCI_CODE_LEN) && (q.c0 == tci_pkg::TCI_CHR_C) && (q.c1 == tci_pkg::TCI_CHR_S);
  assign is_fetch = (q.cnt == tci_pkg::TCI_CODE_LEN) && (q.c0 == tci_pkg::TCI_CHR_G) && (q.c1 == tci_pkg::TCI_CHR_D);

  // sender drives the buffer; payload passes straight from the result source
  assign buf_in_valid = (q.st == tci_pkg::TCI_TX_PAY) ? res_valid : (q.st != tci_pkg::TCI_TX_IDLE);
  assign buf_in_data = (q.st == tci_pkg::TCI_TX_PAY) ? res_data : fixed_byte(q.st, q.idx);
  assign res_ready = (q.st == tci_pkg::TCI_TX_PAY) & buf_in_ready;
  assign push = buf_in_valid & buf_in_ready;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // sender clears pending flags first, so a new request in the same cycle wins
  always_comb begin
    d = q;
    d.clr = 1'b0;
    unique case (q.st)
      tci_pkg::TCI_TX_IDLE: begin
        d.idx = 2'h0;
        if (q.ack_pend) begin
          d.st = tci_pkg::TCI_TX_ACK;
          d.ack_pend = 1'b0;
        end else if (q.fetch_pend || q.acq_pend) begin
          // one telegram serves a fetch and an acquisition that coincide
          d.st = tci_pkg::TCI_TX_RDH;
          d.fetch_pend = 1'b0;
          d.acq_pend = 1'b0;
        end
      end
      tci_pkg::TCI_TX_ACK: begin
        if (push) begin
          d.idx = q.idx + 2'h1;
          if (q.idx == tci_pkg::TCI_ACK_LAST) begin
            d.st = tci_pkg::TCI_TX_CR;
          end
        end
      end
      tci_pkg::TCI_TX_RDH: begin
        if (push) begin
          d.idx = q.idx + 2'h1;
          if (q.idx == tci_pkg::TCI_RD_LAST) begin
            d.st = tci_pkg::TCI_TX_PAY;
          end
        end
      end
      tci_pkg::TCI_TX_PAY: begin
        if (push && res_last) begin
          d.st = tci_pkg::TCI_TX_CR;
        end
      end
      tci_pkg::TCI_TX_CR: begin
        if (push) begin
          d.st = tci_pkg::TCI_TX_LF;
        end
      end
      tci_pkg::TCI_TX_LF: begin
        if (push) begin
          d.st = tci_pkg::TCI_TX_IDLE;
        end
      end
    endcase
    // fetch and acquisition requests die with the connection; a pending ack stays
    if (!conn_up) begin
      d.fetch_pend = 1'b0;
      d.acq_pend = 1'b0;
    end
    if (rx_fire) begin
      if (is_term(rx_data)) begin
        d.cnt = 2'h0;
      end else begin
        if (q.cnt == 2'h0) begin
          d.c0 = rx_data;
        end
        if (q.cnt == 2'h1) begin
          d.c1 = rx_data;
        end
        if (q.cnt != tci_pkg::TCI_CNT_OVER) begin
          d.cnt = q.cnt + 2'h1;
        end
      end
    end
    if (line_end && is_cs) begin
      d.clr = 1'b1;
      d.ack_pend = 1'b1;
    end
    if (line_end && is_fetch && conn_up) begin
      d.fetch_pend = 1'b1;
    end
    if (acq_done && conn_up && !on_request) begin
      d.acq_pend = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // output buffer
  // ----------------------------------------------------------------
  // a receiver stall backs up into the sender and then the result source
  tci_buf u_buf (
    .clock(clock),
    .nrst(nrst),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_port_fixed: assert property (@(posedge clock) disable iff (!nrst)
    listen_port == 16'hc350)
    else $error("listen port not 50000");

  a_clear_on_cs: assert property (@(posedge clock) disable iff (!nrst)
    rx_fire && is_term(rx_data) && is_cs |=> stats_clear && q.ack_pend)
    else $error("clear-statistics not decoded");

  a_clear_needs_term: assert property (@(posedge clock) disable iff (!nrst)
    stats_clear |-> $past(rx_fire) && ($past(rx_data) == 8'h0d || $past(rx_data) == 8'h0a))
    else $error("clear without a terminator");

  a_no_long_code: assert property (@(posedge clock) disable iff (!nrst)
    line_end && q.cnt == 2'h3 |=> !stats_clear && !$rose(q.fetch_pend))
    else $error("overlong line decoded as command");

  a_fetch_queued: assert property (@(posedge clock) disable iff (!nrst)
    line_end && is_fetch && conn_up |=> q.fetch_pend)
    else $error("fetch command not queued");

  a_acq_continuous: assert property (@(posedge clock) disable iff (!nrst)
    acq_done && conn_up && !on_request |=> q.acq_pend)
    else $error("acquisition in continuous mode dropped");

  a_on_request_quiet: assert property (@(posedge clock) disable iff (!nrst)
    $rose(q.acq_pend) |-> $past(acq_done && !on_request && conn_up))
    else $error("acquisition telegram queued in on-request mode");

  a_rd_header: assert property (@(posedge clock) disable iff (!nrst)
    q.st == tci_pkg::TCI_TX_RDH && q.idx == 2'h0 && push
      |=> q.st == tci_pkg::TCI_TX_RDH && buf_in_data == 8'h44)
    else $error("result header letters out of order");

  a_ack_ends_line: assert property (@(posedge clock) disable iff (!nrst)
    q.st == tci_pkg::TCI_TX_ACK && q.idx == 2'h2 && push |=> buf_in_data == 8'h0d)
    else $error("acknowledge not closed by cr");

  a_double_term: assert property (@(posedge clock) disable iff (!nrst)
    rx_fire && is_term(rx_data) && q.cnt == 2'h0 |=> !stats_clear && q.cnt == 2'h0)
    else $error("second terminator treated as a line");

endmodule

/* File: rtl/tci_pkg.sv */
// constants and types shared by the telegram command interpreter
// assumes one 200 MHz clock domain and a byte-wide tcp stream from a stack
package tci_pkg;

  // ----------------------------------------------------------------
  // link and character codes
  // ----------------------------------------------------------------
  localparam logic [15:0] TCI_LISTEN_PORT = 16'hc350; // preset port 50000
  localparam logic [7:0] TCI_CHR_CR = 8'h0d;
  localparam logic [7:0] TCI_CHR_LF = 8'h0a;
  localparam logic [7:0] TCI_CHR_A = 8'h41;
  localparam logic [7:0] TCI_CHR_C = 8'h43;
  localparam logic [7:0] TCI_CHR_D = 8'h44;
  localparam logic [7:0] TCI_CHR_G = 8'h47;
  localparam logic [7:0] TCI_CHR_K = 8'h4b;
  localparam logic [7:0] TCI_CHR_R = 8'h52;
  localparam logic [7:0] TCI_CHR_S = 8'h53;

  // ----------------------------------------------------------------
  // counts and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] TCI_CODE_LEN = 2'h2;  // command code length
  localparam logic [1:0] TCI_CNT_OVER = 2'h3;  // line longer than a code
  localparam logic [1:0] TCI_ACK_LAST = 2'h2;  // index of last ack letter
  localparam logic [1:0] TCI_RD_LAST = 2'h1;   // index of last header letter
  localparam logic [1:0] TCI_BUF_DEPTH = 2'h2; // entries in output buffer
  localparam logic [7:0] TCI_BYTE_RST = 8'h00;

  typedef enum logic [2:0] {
    TCI_TX_IDLE,
    TCI_TX_ACK,
    TCI_TX_RDH,
    TCI_TX_PAY,
    TCI_TX_CR,
    TCI_TX_LF
  } tci_tx_st_t;

endpackage

/* File: rtl/tci_buf.sv */
// two-entry byte buffer between the telegram sender and the tcp stack
// assumes both sides on the same clock; out_data comes from flip-flops
`timescale 1ns/1ps

module tci_buf (
  input wire logic clock,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data
);

  typedef struct packed {
    logic [1:0][7:0] mem;
    logic wr;
    logic rd;
    logic [1:0] cnt;
  } tci_buf_state_t;

  tci_buf_state_t q;
  tci_buf_state_t d;
  logic push;
  logic pop;

  // ----------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------
  // full and empty straight from the count, so a stall really fills it
  assign in_ready = (q.cnt != tci_pkg::TCI_BUF_DEPTH);
  assign out_valid = (q.cnt != 2'h0);
  assign out_data = q.mem[q.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // next state
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = in_data;
      d.wr = ~q.wr;
    end
    if (pop) begin
      d.rd = ~q.rd;
    end
    d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
  end

  // state register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // a stalled word stays put until taken
  a_buf_hold_word: assert property (@(posedge clock) disable iff (!nrst)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffered byte changed while stalled");

endmodule

/* File: testbench/tci_plc_model.sv */
// plc-side model: sends command bytes and collects the answer stream
// assumes the bench calls send_byte and idle; inputs move at the falling edge
`timescale 1ns/1ps

module tci_plc_model (
  input wire logic clock,
  input wire logic stall,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data
);
  string got = "";
  int hung = 0;
  logic tgl = 1'b0;

  // ----------------------------------------------------------------
  // command side
  // ----------------------------------------------------------------
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
  end

  task automatic send_byte(input logic [7:0] b);
    int n;
    n = 0;
    @(negedge clock);
    rx_valid = 1'b1;
    rx_data = b;
    while (rx_ready !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    if (n == 300) hung++;
    @(posedge clock);
  endtask

  // released line shows the inverse, never a stale byte
  task automatic idle();
    @(negedge clock);
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask

  // ----------------------------------------------------------------
  // answer side
  // ----------------------------------------------------------------
  // ready is ragged under stall; tx_data is flopped, so it is steady till the rise
  always @(negedge clock) begin
    tgl = ~tgl;
    tx_ready = ~stall | tgl;
    if (tx_valid === 1'b1 && tx_ready === 1'b1) got = $sformatf("%s%c", got, tx_data);
  end
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the telegram command interpreter
// assumes the plc model in tci_plc_model.sv; result source lives here
`timescale 1ns/1ps

module testbench;
  logic clock, nrst, conn_up, on_request, acq_done, stats_clear, stall;
  logic rx_valid, rx_ready, res_valid, res_ready, res_last, tx_valid, tx_ready;
  logic [7:0] rx_data, res_data, tx_data;
  logic [15:0] listen_port;
  int errors = 0;
  int total_checks = 0;
  int clr_n = 0;
  int idx = 0;
  logic take = 1'b0;
  string pay = "5901,40";
  string rd;
  string terms[3] = '{"\r", "\n", "\r\n"};

  tci_interp dut_u (.clock(clock), .nrst(nrst), .listen_port(listen_port), .conn_up(conn_up),
    .on_request(on_request), .acq_done(acq_done), .stats_clear(stats_clear), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .res_valid(res_valid), .res_ready(res_ready),
    .res_data(res_data), .res_last(res_last), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
  tci_plc_model plc_u (.clock(clock), .stall(stall), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));

  // ----------------------------------------------------------------
  // clock, result source, clear counter
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // res_ready comes from flops only, so it is steady over the low phase
  always @(negedge clock) begin
    if (take) idx = (idx == pay.len() - 1) ? 0 : idx + 1;
    res_data = pay[idx];
    res_last = (idx == pay.len() - 1);
    res_valid = 1'b1;
    take = (res_ready === 1'b1);
    if (stats_clear === 1'b1) clr_n++;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    errors += plc_u.hung;
    $display("errors=%0d total_checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check_str(input string g, input string e);
    total_checks++;
    if (g != e) begin
      errors++;
      $display("Error at %0t: stream mismatch, got %0d bytes, want %0d", $time, g.len(), e.len());
    end
  endtask

  task automatic check_bits(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: value %h, want %h", $time, g, e);
    end
  endtask

  task automatic send_line(input logic [7:0] a, input logic [7:0] b, input string t);
    plc_u.send_byte(a);
    plc_u.send_byte(b);
    for (int i = 0; i < t.len(); i++) plc_u.send_byte(t[i]);
    plc_u.idle();
    if (plc_u.hung != 0) report_and_stop();
  endtask

  // bounded wait for n answer bytes, then a quiet spell to catch extras
  task automatic settle(input int n);
    int k;
    k = 0;
    while (plc_u.got.len() < n && k < 400) begin
      @(negedge clock);
      k++;
    end
    if (k == 400) begin
      errors++;
      report_and_stop();
    end else begin
      repeat (40) @(negedge clock);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic sc_reset();
    check_bits(listen_port, 16'hc350);
    check_bits({15'h0000, tx_valid}, 16'h0000);
  endtask

  // every terminator form, cr lf giving one answer only
  task automatic sc_clear();
    foreach (terms[i]) begin
      plc_u.got = "";
      clr_n = 0;
      send_line(tci_pkg::TCI_CHR_C, tci_pkg::TCI_CHR_S, terms[i]);
      settle(5);
      check_str(plc_u.got, "ACK\r\n");
      check_bits(clr_n[15:0], 16'h0001);
    end
  endtask

  // code with a parameter and a one-letter line are not clear commands
  task automatic sc_bad_lines();
    plc_u.got = "";
    clr_n = 0;
    send_line(tci_pkg::TCI_CHR_C, tci_pkg::TCI_CHR_S, "X\r");
    send_line(tci_pkg::TCI_CHR_C, tci_pkg::TCI_CHR_CR, "");
    repeat (60) @(negedge clock);
    check_bits(clr_n[15:0], 16'h0000);
    check_str(plc_u.got, "");
  endtask

  // a fetch gets the bare result telegram, no acknowledge before it
  task automatic sc_fetch(input logic req);
    on_request = req;
    conn_up = 1'b1;
    plc_u.got = "";
    send_line(tci_pkg::TCI_CHR_G, tci_pkg::TCI_CHR_D, "\r\n");
    settle(rd.len());
    check_str(plc_u.got, rd);
  endtask

  task automatic sc_acq(input logic req, input logic conn, input logic stl, input string e);
    on_request = req;
    conn_up = conn;
    stall = stl;
    plc_u.got = "";
    @(negedge clock);
    acq_done = 1'b1;
    @(negedge clock);
    acq_done = 1'b0;
    if (e.len() > 0) settle(e.len());
    else repeat (60) @(negedge clock);
    check_str(plc_u.got, e);
    stall = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    conn_up = 1'b0;
    on_request = 1'b0;
    acq_done = 1'b0;
    stall = 1'b0;
    rd = {"RD", pay, "\r\n"};
    repeat (7) @(negedge clock);
    nrst = 1'b1;
    sc_reset();
    sc_clear();
    sc_bad_lines();
    sc_fetch(1'b1);
    sc_acq(1'b1, 1'b1, 1'b0, "");
    sc_acq(1'b0, 1'b1, 1'b1, rd);
    sc_acq(1'b0, 1'b0, 1'b0, "");
    sc_fetch(1'b0);
    report_and_stop();
  end
endmodule
